// [respiration_control_consts.vh]
// constants for the respiration modulation control block
// assumes a 20 MHz master clock; included by the design files only
`ifndef RESPIRATION_CONTROL_CONSTS_VH
`define RESPIRATION_CONTROL_CONSTS_VH

// respiration control register fields
`define RC_MOD_EN_BIT 7
`define RC_DEMOD_EN_BIT 6
`define RC_PHASE_HI 4
`define RC_PHASE_LO 2
`define RC_SRC_HI 1
`define RC_SRC_LO 0
`define RC_SRC_INTERNAL 2'h2
`define RC_RESET 8'h00

// fourth configuration register, carrier frequency field
`define CF4_FREQ_HI 7
`define CF4_FREQ_LO 5
`define CF4_FREQ_64K 3'h1
`define CF4_RESET 8'h00

// timing
`define CLOCK_HZ 20000000
`define CARRIER_32K_HZ 32000
`define CARRIER_64K_HZ 64000
`define DATA_RATE_MAX_SPS 32000
// one carrier period is split into 16 phase steps of 22.5 degrees
`define PHASE_STEPS 16
// the step length is rounded down so a carrier is never slower than named
`define STEP_32K_CYC (`CLOCK_HZ / (`CARRIER_32K_HZ * `PHASE_STEPS))
`define STEP_64K_CYC (`CLOCK_HZ / (`CARRIER_64K_HZ * `PHASE_STEPS))
`define RATE_MIN_CYC ((`CLOCK_HZ + `DATA_RATE_MAX_SPS - 1) / `DATA_RATE_MAX_SPS)
// rate length loaded at reset: the 625-cycle minimum, the converter ceiling
`define RATE_LEN_RESET 16'h0271

`endif

// [step_divider.v]
// step divider: emits a one-cycle tick every step_len clock cycles
// assumes step_len is held stable by the caller while running
`include "respiration_control_consts.vh"

module step_divider (
  input wire clock,
  input wire reset,
  input wire run,
  input wire [7:0] step_len,
  output reg tick_r
);

  reg [7:0] count_r;

  // count down, reload on the tick; idle holds the counter cleared
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (!run) begin
      count_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (count_r == 8'h00) begin
      count_r <= step_len - 8'h01;
      tick_r <= 1'b1;
    end else begin
      count_r <= count_r - 8'h01;
      tick_r <= 1'b0;
    end
  end

endmodule // step_divider

// [respiration_modulation_control.v]
// respiration modulation and demodulation clocking, channel 1 routing, rate guard
// assumes configuration bytes are written synchronously to clock by the host side
// How it works
// - both upper enable bits gate mod and demod
// - bits four to two select demod phase
// - source field 10b selects internal modulation
// - config four bits select 32 or 64 kHz
// - positive and negative outputs opposite while active, both low when idle
// - respiration mode takes channel 1 away
// - phase setting delays demod clock after mod
// - demod flips channel 1 sample by carrier
// - one data rate for every channel
// - output rate never above 32 kSPS
// - pace buffer routes any selected channel out
`include "respiration_control_consts.vh"

module respiration_modulation_control (
  input wire clock,
  input wire reset,
  input wire [7:0] respiration_control,
  input wire [7:0] config_reg_four,
  input wire [15:0] data_rate_div,
  input wire [2:0] pace_select,
  input wire pace_enable,
  input wire [7:0] channel_pace_in,
  input wire [23:0] channel1_sample,
  input wire channel1_sample_valid,
  output reg carrier_out_pos,
  output reg carrier_out_neg,
  output reg demod_clock_r,
  output reg respiration_control_active_r,
  output reg channel1_ecg_enable_r,
  output reg [23:0] respiration_control_demod_r,
  output reg respiration_control_demod_valid_r,
  output reg conversion_strobe_r,
  output reg pace_buffer_output,
  output reg pace_buffer_enable_r
);

  // timing of one carrier period, in master clock cycles:
  //   the divider ticks once per step length, 39 cycles at 32 kHz and 19 at 64 kHz
  //   sixteen ticks make one period, so one step is 22.5 degrees of carrier
  //   the tick that ends step 15 latches the enable, frequency and phase settings
  //   one edge later the pins, the status and the channel 1 owner all change
  //   the demod clock has the carrier's shape, moved later by the phase code in steps
  //   the conversion strobe runs on its own counter, apart from the carrier
  // limitation: step lengths are rounded down, so both carriers run a little fast
  // limitation: a setting written and removed inside one period is never seen
  // trade-off: up to one period of latency buys carrier pulses that are never cut short
  // trade-off: settings are not synchronised here; the host side writes on clock

  // carrier timing and the settings latched at the last period edge
  reg active_r;
  reg active_nxt;
  reg freq64_r;
  reg freq64_nxt;
  reg [2:0] phase_r;
  reg [2:0] phase_nxt;
  reg [3:0] step_r;
  reg [3:0] step_nxt;
  // carrier stage values ahead of their flip-flops
  reg pos_nxt;
  reg neg_nxt;
  reg demod_clock_nxt;
  reg respiration_control_active_nxt;
  reg channel1_ecg_enable_nxt;
  // demodulator values ahead of their flip-flops
  reg [23:0] respiration_control_demod_nxt;
  reg respiration_control_demod_valid_nxt;
  // conversion rate generator
  reg [15:0] rate_count_r;
  reg [15:0] rate_count_nxt;
  reg [15:0] rate_len_r;
  reg [15:0] rate_len_nxt;
  reg conversion_strobe_nxt;
  // pace routing values ahead of their flip-flops
  reg pace_picked;
  reg pace_buffer_output_nxt;
  reg pace_buffer_enable_nxt;
  // decoded settings and divider wiring
  wire step_tick;
  wire period_end;
  wire [31:0] step_len_full;
  wire [7:0] step_len;
  wire want_active;
  wire want_freq64;
  wire [2:0] want_phase;
  // delayed step count and helper values
  wire [3:0] demod_step;
  wire [23:0] sample_negated;
  wire [31:0] rate_min_full;
  wire [15:0] rate_min;

  // both enables and the internal source must be set together
  // any other source code leaves the block idle: the external modulation
  // path is not built here, so there is nothing to drive in that case
  assign want_active = respiration_control[`RC_MOD_EN_BIT] &
    respiration_control[`RC_DEMOD_EN_BIT] &
    (respiration_control[`RC_SRC_HI:`RC_SRC_LO] == `RC_SRC_INTERNAL);
  // every frequency code but the 64 kHz one falls back to 32 kHz
  assign want_freq64 = (config_reg_four[`CF4_FREQ_HI:`CF4_FREQ_LO] == `CF4_FREQ_64K);
  assign want_phase = respiration_control[`RC_PHASE_HI:`RC_PHASE_LO];

  // the length follows the next frequency, but the first step of a new period
  // was loaded at the tick ending step 15 and keeps the old length; the constants are 32 bits wide
  assign step_len_full = freq64_nxt ? `STEP_64K_CYC : `STEP_32K_CYC;
  assign step_len = step_len_full[7:0];
  // one phase code is one step of 22.5 degrees, so the codes span 0 to 157.5
  // the subtraction wraps modulo 16, which is exactly one carrier period
  assign demod_step = step_r - {1'b0, phase_r};
  // the tick that closes step 15 is the carrier period boundary
  assign period_end = step_tick & (step_r == 4'hF);
  // a square carrier only needs its sign taken off again
  assign sample_negated = 24'h000000 - channel1_sample;
  assign rate_min_full = `RATE_MIN_CYC;
  assign rate_min = rate_min_full[15:0];

  // divider runs always so a disabled block can start on a clean edge
  // it only reads its length at a reload, so a change never cuts a step
  step_divider u_step (
    .clock(clock),
    .reset(reset),
    .run(1'b1),
    .step_len(step_len),
    .tick_r(step_tick)
  );

  // step counter advances once per tick; settings move only at the period end
  // the counter runs while idle too, so the first pulse after enabling is whole
  always @* begin
    step_nxt = step_r;
    active_nxt = active_r;
    freq64_nxt = freq64_r;
    phase_nxt = phase_r;
    if (step_tick) begin
      step_nxt = step_r + 4'h1;
    end
    if (period_end) begin
      // updating only here avoids runt carrier pulses
      active_nxt = want_active;
      freq64_nxt = want_freq64;
      phase_nxt = want_phase;
    end
  end

  // step and settings flip-flops
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      step_r <= 4'h0;
      active_r <= 1'b0;
      freq64_r <= 1'b0;
      phase_r <= 3'h0;
    end else begin
      step_r <= step_nxt;
      active_r <= active_nxt;
      freq64_r <= freq64_nxt;
      phase_r <= phase_nxt;
    end
  end

  // carrier: high for steps 0 to 7, low for steps 8 to 15
  // both pins come from one step bit, so they can never overlap high
  always @* begin
    // idle parks both at the low reference level
    pos_nxt = 1'b0;
    neg_nxt = 1'b0;
    demod_clock_nxt = 1'b0;
    if (active_r) begin
      pos_nxt = ~step_r[3];
      neg_nxt = step_r[3];
      // same shape as the carrier, read from the delayed step count
      demod_clock_nxt = ~demod_step[3];
    end
    // the status and the channel 1 owner switch with the carrier itself
    respiration_control_active_nxt = active_r;
    channel1_ecg_enable_nxt = ~active_r;
  end

  // carrier pins come from flip-flops so they never glitch
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      carrier_out_pos <= 1'b0;
      carrier_out_neg <= 1'b0;
      demod_clock_r <= 1'b0;
      respiration_control_active_r <= 1'b0;
      channel1_ecg_enable_r <= 1'b1;
    end else begin
      carrier_out_pos <= pos_nxt;
      carrier_out_neg <= neg_nxt;
      demod_clock_r <= demod_clock_nxt;
      respiration_control_active_r <= respiration_control_active_nxt;
      channel1_ecg_enable_r <= channel1_ecg_enable_nxt;
    end
  end

  // demodulator: sign-flip each sample with the delayed clock
  // the registered demod clock lags its step count by one master clock,
  // which is far below one step and is taken up by the phase setting
  always @* begin
    respiration_control_demod_nxt = respiration_control_demod_r;
    respiration_control_demod_valid_nxt = 1'b0;
    if (active_r && channel1_sample_valid) begin
      respiration_control_demod_valid_nxt = 1'b1;
      // carrier removed; offset and slow impedance change remain
      if (demod_clock_r) begin
        respiration_control_demod_nxt = channel1_sample;
      end else begin
        respiration_control_demod_nxt = sample_negated;
      end
    end
  end

  // the last result is held between samples; samples while idle are dropped
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      respiration_control_demod_r <= 24'h000000;
      respiration_control_demod_valid_r <= 1'b0;
    end else begin
      respiration_control_demod_r <= respiration_control_demod_nxt;
      respiration_control_demod_valid_r <= respiration_control_demod_valid_nxt;
    end
  end

  // one conversion strobe shared by all channels
  // a per-channel rate would need a counter per channel; there is only one
  always @* begin
    // clamp keeps the rate at or below the converter ceiling
    if (data_rate_div < rate_min) begin
      rate_len_nxt = rate_min;
    end else begin
      rate_len_nxt = data_rate_div;
    end
    // a new length is used from the next reload, never mid-count
    if (rate_count_r == 16'h0000) begin
      rate_count_nxt = rate_len_r - 16'h0001;
      conversion_strobe_nxt = 1'b1;
    end else begin
      rate_count_nxt = rate_count_r - 16'h0001;
      conversion_strobe_nxt = 1'b0;
    end
  end

  // reset loads the shortest legal length, so the first reload cannot wrap
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rate_count_r <= 16'h0000;
      rate_len_r <= `RATE_LEN_RESET;
      conversion_strobe_r <= 1'b0;
    end else begin
      rate_count_r <= rate_count_nxt;
      rate_len_r <= rate_len_nxt;
      conversion_strobe_r <= conversion_strobe_nxt;
    end
  end

  // pace buffer routing: a single-ended copy of one channel
  // any channel may be picked, also channel 1 while respiration runs
  always @* begin
    case (pace_select)
      3'h0: pace_picked = channel_pace_in[0];
      3'h1: pace_picked = channel_pace_in[1];
      3'h2: pace_picked = channel_pace_in[2];
      3'h3: pace_picked = channel_pace_in[3];
      3'h4: pace_picked = channel_pace_in[4];
      3'h5: pace_picked = channel_pace_in[5];
      3'h6: pace_picked = channel_pace_in[6];
      3'h7: pace_picked = channel_pace_in[7];
      default: pace_picked = 1'b0;
    endcase
    // disabled buffer shows the low level rather than a stale channel
    pace_buffer_output_nxt = pace_enable & pace_picked;
    pace_buffer_enable_nxt = pace_enable;
  end

  // one cycle late, like every other output of the block
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      pace_buffer_output <= 1'b0;
      pace_buffer_enable_r <= 1'b0;
    end else begin
      pace_buffer_output <= pace_buffer_output_nxt;
      pace_buffer_enable_r <= pace_buffer_enable_nxt;
    end
  end

endmodule // respiration_modulation_control

// [rmc_checker.sv]
// assertions on the respiration modulation control ports
// bound to the top module; one clock, reset async active high
module rmc_checker (
  input wire clock,
  input wire reset,
  input wire [7:0] respiration_control,
  input wire [2:0] pace_select,
  input wire pace_enable,
  input wire [7:0] channel_pace_in,
  input wire carrier_out_pos,
  input wire carrier_out_neg,
  input wire respiration_control_active_r,
  input wire channel1_ecg_enable_r,
  input wire conversion_strobe_r,
  input wire pace_buffer_output
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // settings are latched one edge before the outputs change, two samples before the check sees them
  wire want_w = respiration_control[7:6] == 2'h3 && respiration_control[1:0] == 2'h2;
  a_carrier_opposite: assert property (respiration_control_active_r |-> carrier_out_pos != carrier_out_neg)
    else $error("carrier outputs not opposite");
  a_idle_quiet: assert property (!respiration_control_active_r |-> !(carrier_out_pos | carrier_out_neg))
    else $error("carrier driven while idle");
  a_channel_handover: assert property (channel1_ecg_enable_r != respiration_control_active_r)
    else $error("channel 1 owner wrong");
  a_start_needs_bits: assert property ($rose(respiration_control_active_r) |-> $past(want_w, 2))
    else $error("started without both enables and source");
  a_start_full_pulse: assert property ($rose(respiration_control_active_r) |-> carrier_out_pos)
    else $error("start not on period boundary");
  a_half_period_min: assert property ($rose(carrier_out_pos) |=> carrier_out_pos [*8])
    else $error("carrier half period too short");
  a_pace_route: assert property (pace_buffer_output == $past(channel_pace_in[pace_select] & pace_enable))
    else $error("pace output wrong");
  a_strobe_single: assert property (conversion_strobe_r |=> !conversion_strobe_r [*8])
    else $error("strobe too close");
  c_start: cover property ($rose(respiration_control_active_r));
  c_stop: cover property ($fell(respiration_control_active_r));
  c_strobe: cover property (conversion_strobe_r);
endmodule // rmc_checker

bind respiration_modulation_control rmc_checker rmc_checker_i (.*);

// [electrode_model.sv]
// electrode network stand-in feeding channel 1 samples
// assumes the positive carrier drives it; one sample every 64 clocks
module electrode_model (
  input wire clock,
  input wire carrier,
  output logic [23:0] sample = 24'h000000,
  output logic valid = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_r = 6'h00;
  // body returns the carrier with its sign around a zero offset
  always @(posedge clock) begin
    cnt_r <= cnt_r + 6'h01;
    valid <= cnt_r == 6'h3F;
    sample <= carrier ? 24'h001200 : 24'hFFEE00;
  end
endmodule // electrode_model

// [tb.sv]
// bench for the respiration modulation control block
// inputs driven on the rising edge, outputs sampled on the falling edge
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset = 1, pace_enable = 0, channel1_sample_valid;
  logic [7:0] respiration_control = 8'h00, config_reg_four = 8'h00, channel_pace_in = 8'h20;
  logic [15:0] data_rate_div = 16'h0010;
  logic [2:0] pace_select = 3'h5;
  logic [23:0] channel1_sample, respiration_control_demod_r;
  logic carrier_out_pos, carrier_out_neg, demod_clock_r, respiration_control_active_r, channel1_ecg_enable_r;
  logic respiration_control_demod_valid_r, conversion_strobe_r, pace_buffer_output, pace_buffer_enable_r;
  int miscompares = 0, tests_run = 0, cyc = 0, n;
  respiration_modulation_control respiration_modulation_control_i (.*);
  electrode_model electrode_model_i (.clock, .carrier(carrier_out_pos),
    .sample(channel1_sample), .valid(channel1_sample_valid));
  initial forever #25 clock = ~clock;
  // hang guard, far above the roughly 5000 cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      wrap_up;
    end
  end
  task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", s, exp, seen);
    end
  endtask
  task automatic ticks(int k);
    repeat (k) @(negedge clock);
  endtask
  // a change waits up to one carrier period, so 700 cycles covers it
  task automatic setup(logic [7:0] rc);
    @(posedge clock);
    respiration_control <= rc;
    ticks(700);
  endtask
  task automatic pos_rise;
    do ticks(1); while (carrier_out_pos !== 1'b0);
    do ticks(1); while (carrier_out_pos !== 1'b1);
    n = 0;
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    setup(8'h82);
    check("one enable", respiration_control_active_r, 0);
    setup(8'hC1);
    check("bad source", respiration_control_active_r, 0);
    check("ch1 free", channel1_ecg_enable_r, 1);
    $display("test idle done");
    setup(8'hC2);
    check("active", respiration_control_active_r, 1);
    check("ch1 taken", channel1_ecg_enable_r, 0);
    pos_rise;
    check("neg low", carrier_out_neg, 0);
    while (carrier_out_pos === 1'b1) begin
      n++;
      ticks(1);
    end
    check("32k half", n, 312);
    $display("test 32k done");
    @(posedge clock);
    config_reg_four <= 8'h20;
    setup(8'hDA);
    pos_rise;
    while (demod_clock_r !== 1'b0) begin
      n++;
      ticks(1);
    end
    while (demod_clock_r !== 1'b1) begin
      n++;
      ticks(1);
    end
    // code 6 is six steps of 19 clocks between carrier and demod rise
    check("demod delay", n, 114);
    pos_rise;
    while (carrier_out_pos === 1'b1) begin
      n++;
      ticks(1);
    end
    check("64k half", n, 152);
    do ticks(1); while (respiration_control_demod_valid_r !== 1'b1 && cyc < 19000);
    check("demod out", respiration_control_demod_valid_r, 1);
    check("demod size", respiration_control_demod_r == 24'h001200 || respiration_control_demod_r == 24'hFFEE00, 1);
    $display("test 64k done");
    check("pace off", pace_buffer_output, 0);
    @(posedge clock);
    pace_enable <= 1'b1;
    ticks(2);
    check("pace out", pace_buffer_output, 1);
    check("pace en", pace_buffer_enable_r, 1);
    do ticks(1); while (conversion_strobe_r !== 1'b1);
    n = 0;
    do begin
      n++;
      ticks(1);
    end while (conversion_strobe_r !== 1'b1);
    check("rate gap", n, 625);
    $display("test pace rate done");
    wrap_up;
  end
endmodule // tb
